// ===== verilog/adc_cal_pkg.sv
// Constants for the two-point converter correction datapath.
// Assumes one 10 MHz core clock and fuse trim bytes that stay stable.
`default_nettype none
package adc_cal_pkg;
  // Code range of the general_purpose_converter
  localparam int CODE_W = 12;
  localparam logic [11:0] CODE_MAX = 12'hFFF;
  localparam int CH_W = 5;
  // Reference input codes shared by all corrected groups
  localparam int REF_X1 = 1441;
  localparam int REF_X2 = 3276;
  // Datapath widths
  localparam int MAG_W = 9;
  localparam int DEV_W = 11;
  localparam int NUM_W = 26;
  localparam int DIVIDEND_W = 25;
  localparam int DIVISOR_W = 13;
  localparam logic [4:0] DIV_STEPS = 5'h19;
  // Channel selection
  localparam logic [31:0] GROUP_A_MASK = 32'h0000307F;
  localparam logic [4:0] CH_EXTRA_A = 5'h08;
  localparam logic [4:0] CH_EXTRA_B = 5'h09;
  // Field positions in the fuse bytes
  localparam int SIGN_BIT = 0;
  localparam int LO2_MSB = 2;
  localparam int LO4_MSB = 4;
  localparam int HI5_MSB = 4;
  localparam int HI6_MSB = 5;
  localparam int HI2_MSB = 4;
  localparam int HI2_LSB = 3;
  // Reset values
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [4:0] CH_RST = 5'h00;
  // Cycles from accept edge to the result pulse
  localparam int RESULT_LATENCY = 28;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_DIV} cal_state_t;
endpackage
`default_nettype wire

// ===== verilog/sm_term.sv
// Sign-magnitude to two's complement decoder for one trim deviation.
// Assumes the sign bit has been split off the fuse field already.
`timescale 1ns/1ps
`default_nettype none
module sm_term
  import adc_cal_pkg::*;
(
  input wire logic [MAG_W-1:0] mag_in, // Unsigned magnitude
  input wire logic sign_in, // High means negative
  output logic signed [DEV_W-1:0] value_out // Signed deviation
);
  // Zero-extended magnitude so negation cannot overflow
  logic signed [DEV_W-1:0] mag_ext;
  assign mag_ext = $signed({{(DEV_W-MAG_W){1'b0}}, mag_in});
  // A minus zero simply yields zero, no special case needed
  assign value_out = sign_in ? -mag_ext : mag_ext;
endmodule
`default_nettype wire

// ===== verilog/cal_divider.sv
// Restoring unsigned divider, one quotient bit per clock.
// Assumes the caller holds off a new start until done has pulsed.
`timescale 1ns/1ps
`default_nettype none
module cal_divider
  import adc_cal_pkg::*;
(
  input wire logic ref_clk_in, // Core clock
  input wire logic reset_in, // Synchronous, active high
  input wire logic start_in, // Loads operands
  input wire logic [DIVIDEND_W-1:0] dividend_in, // Numerator
  input wire logic [DIVISOR_W-1:0] divisor_in, // Nonzero denominator
  output logic done_out, // One-cycle pulse, quotient valid
  output logic [DIVIDEND_W-1:0] quotient_out // Floor of the ratio
);
  logic [DIVISOR_W-1:0] rem_q; // Partial remainder
  logic [DIVIDEND_W-1:0] quo_q; // Dividend shifting into quotient
  logic [DIVISOR_W-1:0] den_q; // Held divisor
  logic [4:0] cnt_q; // Steps left
  logic done_q; // Completion pulse
  // Shift in the next dividend bit; one extra bit guards the compare
  logic [DIVISOR_W:0] shifted;
  logic [DIVISOR_W:0] trial;
  logic fits;
  assign shifted = {rem_q, quo_q[DIVIDEND_W-1]};
  assign trial = shifted - {1'b0, den_q};
  assign fits = shifted >= {1'b0, den_q};
  assign done_out = done_q;
  assign quotient_out = quo_q;
  // One iteration per edge while steps remain
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end else if (start_in) begin
      rem_q <= '0;
      quo_q <= dividend_in;
      den_q <= divisor_in;
      cnt_q <= DIV_STEPS;
      done_q <= 1'b0;
    end else if (cnt_q != 5'h00) begin
      rem_q <= fits ? trial[DIVISOR_W-1:0] : shifted[DIVISOR_W-1:0];
      quo_q <= {quo_q[DIVIDEND_W-2:0], fits};
      cnt_q <= cnt_q - 5'h01;
      done_q <= (cnt_q == 5'h01);
    end else begin
      done_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/adc_two_point_calibration.sv
// Two-point gain and offset correction of raw converter codes.
// Assumes fuse bytes are stable while a request is in flight and that
// requests arrive only with raw_ready_out high.
//
// Function
// - Correct each group from two reference points
// - Gain is one plus deviation slope
// - Offset is D1 minus gain excess times X1
// - Output is raw minus offset over gain
// - Group A uses 1441, 3276, channel-3 trims
// - Channel-3 D1 from fuse 3, fuse 1
// - Channel-3 D2 from fuse 4, fuse 2
// - Channels 8, 9 add own deviation
// - Channel-8 extra D1 from fuse 8, 7
// - Channel-8 extra D2 from fuse 10, 8
// - Channel-9 extra D1 from fuse 14, 12
// - Channel-9 extra D2 from fuse 16, 14
// - Deviations are sign-magnitude, LSB is sign
// - Codes span 0 to 4095
`timescale 1ns/1ps
`default_nettype none
module adc_two_point_calibration
  import adc_cal_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] cal_fuse_reg_1_in,
  input wire logic [7:0] cal_fuse_reg_2_in,
  input wire logic [7:0] cal_fuse_reg_3_in,
  input wire logic [7:0] cal_fuse_reg_4_in,
  input wire logic [7:0] cal_fuse_reg_7_in,
  input wire logic [7:0] cal_fuse_reg_8_in,
  input wire logic [7:0] cal_fuse_reg_10_in,
  input wire logic [7:0] cal_fuse_reg_12_in,
  input wire logic [7:0] cal_fuse_reg_14_in,
  input wire logic [7:0] cal_fuse_reg_16_in,
  input wire logic [CH_W-1:0] channel_in,
  input wire logic [CODE_W-1:0] raw_code_in,
  input wire logic raw_valid_in,
  output logic raw_ready_out,
  output logic [CODE_W-1:0] corrected_code_out,
  output logic [CH_W-1:0] result_channel_out,
  output logic result_valid_out,
  output logic cal_applied_out,
  output logic clamped_out
);

  // Sequencer and captured request
  cal_state_t state_q; // Current step
  cal_state_t state_d; // Next step
  logic [CODE_W-1:0] raw_q; // Latched raw code
  logic [CH_W-1:0] chan_q; // Latched channel
  logic applied_q; // Latched correction flag
  logic signed [DEV_W-1:0] d1_q; // Latched low-point deviation
  logic signed [DEV_W-1:0] d2_q; // Latched high-point deviation
  logic neg_q; // Numerator went below zero
  // Result registers
  logic [CODE_W-1:0] code_q; // Corrected code
  logic valid_q; // Result pulse
  logic clamp_q; // Output was saturated

  // Request handshake
  logic accepted;
  assign raw_ready_out = (state_q == ST_IDLE);
  assign accepted = raw_valid_in && raw_ready_out;

  // Channel grouping; unlisted channels pass with zero deviation
  logic grp_a; // Channel-3 trims only
  logic is_ch8; // Channel-3 plus channel-8 extras
  logic is_ch9; // Channel-3 plus channel-9 extras
  logic grp_any; // Any corrected channel
  assign grp_a = GROUP_A_MASK[channel_in];
  assign is_ch8 = (channel_in == CH_EXTRA_A);
  assign is_ch9 = (channel_in == CH_EXTRA_B);
  assign grp_any = grp_a || is_ch8 || is_ch9;

  // Magnitudes, scaled by concatenation: x4 and x16 become bit shifts
  logic [MAG_W-1:0] mag [6];
  logic [5:0] sgn;
  assign mag[0] = MAG_W'({cal_fuse_reg_3_in[HI5_MSB:0],
                          cal_fuse_reg_1_in[LO2_MSB:1]});
  assign sgn[0] = cal_fuse_reg_1_in[SIGN_BIT];
  assign mag[1] = MAG_W'({cal_fuse_reg_4_in[HI6_MSB:0],
                          cal_fuse_reg_2_in[LO2_MSB:1]});
  assign sgn[1] = cal_fuse_reg_2_in[SIGN_BIT];
  assign mag[2] = MAG_W'({cal_fuse_reg_8_in[HI2_MSB:HI2_LSB],
                          cal_fuse_reg_7_in[LO4_MSB:1]});
  assign sgn[2] = cal_fuse_reg_7_in[SIGN_BIT];
  assign mag[3] = MAG_W'({cal_fuse_reg_10_in[HI5_MSB:0],
                          cal_fuse_reg_8_in[LO2_MSB:1]});
  assign sgn[3] = cal_fuse_reg_8_in[SIGN_BIT];
  assign mag[4] = MAG_W'({cal_fuse_reg_14_in[HI2_MSB:HI2_LSB],
                          cal_fuse_reg_12_in[LO4_MSB:1]});
  assign sgn[4] = cal_fuse_reg_12_in[SIGN_BIT];
  assign mag[5] = MAG_W'({cal_fuse_reg_16_in[HI5_MSB:0],
                          cal_fuse_reg_14_in[LO2_MSB:1]});
  assign sgn[5] = cal_fuse_reg_14_in[SIGN_BIT];

  // Each field decoded as sign-magnitude, never two's complement
  logic signed [DEV_W-1:0] dev_term [6];
  for (genvar i = 0; i < 6; i++) begin : g_term
    sm_term u_term (
      .mag_in(mag[i]),
      .sign_in(sgn[i]),
      .value_out(dev_term[i])
    );
  end

  // Extra term for channels 8 and 9, zero elsewhere
  logic signed [DEV_W-1:0] extra_d1;
  logic signed [DEV_W-1:0] extra_d2;
  logic signed [DEV_W-1:0] d1_d;
  logic signed [DEV_W-1:0] d2_d;
  assign extra_d1 = is_ch8 ? dev_term[2] :
                    (is_ch9 ? dev_term[4] : '0);
  assign extra_d2 = is_ch8 ? dev_term[3] :
                    (is_ch9 ? dev_term[5] : '0);
  // Uncorrected channels get D1 = D2 = 0, which is the identity map
  assign d1_d = grp_any ? dev_term[0] + extra_d1 : '0;
  assign d2_d = grp_any ? dev_term[1] + extra_d2 : '0;

  // Zero-extended raw code and sign-extended deviations for the closed-form correction
  logic signed [NUM_W-1:0] a_ext;
  logic signed [NUM_W-1:0] d1_ext;
  logic signed [NUM_W-1:0] d2_ext;
  logic signed [NUM_W-1:0] dx_s;
  logic signed [NUM_W-1:0] x1_s;
  assign a_ext = $signed({{(NUM_W-CODE_W){1'b0}}, raw_q});
  assign d1_ext = {{(NUM_W-DEV_W){d1_q[DEV_W-1]}}, d1_q};
  assign d2_ext = {{(NUM_W-DEV_W){d2_q[DEV_W-1]}}, d2_q};
  assign dx_s = NUM_W'(REF_X2 - REF_X1);
  assign x1_s = NUM_W'(REF_X1);

  // With k = (dX + D2 - D1)/dX and b = D1 - (k-1)X1, (a-b)/k equals
  // ((a-D1)dX + (D2-D1)X1) / (dX + D2 - D1). Folding it avoids any
  // fractional k, so no precision is lost before the one division.
  logic signed [NUM_W-1:0] num;
  logic signed [NUM_W-1:0] den;
  assign num = (a_ext - d1_ext) * dx_s
             + (d2_ext - d1_ext) * x1_s;
  assign den = dx_s + d2_ext - d1_ext;

  // Round to nearest: floor((2N + D) / 2D); negatives clamp to zero
  logic num_neg;
  logic [NUM_W-1:0] round_sum;
  logic [DIVIDEND_W-1:0] dividend;
  logic [DIVISOR_W-1:0] divisor;
  assign num_neg = num[NUM_W-1];
  assign round_sum = {num[NUM_W-2:0], 1'b0} + den;
  assign dividend = num_neg ? '0 : round_sum[DIVIDEND_W-1:0];
  assign divisor = {den[DIVISOR_W-2:0], 1'b0};

  // Divider runs while the sequencer waits
  logic div_start;
  logic div_done;
  logic [DIVIDEND_W-1:0] quotient;
  assign div_start = (state_q == ST_LOAD);
  cal_divider u_div (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .start_in(div_start),
    .dividend_in(dividend),
    .divisor_in(divisor),
    .done_out(div_done),
    .quotient_out(quotient)
  );

  // Saturate to the 12-bit code range
  logic over;
  logic [CODE_W-1:0] sat_code;
  assign over = (quotient > DIVIDEND_W'(CODE_MAX));
  assign sat_code = over ? CODE_MAX : quotient[CODE_W-1:0];

  // Next-state decode
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accepted) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_d = ST_DIV;
      end
      ST_DIV: begin
        if (div_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Capture the request; trims are sampled with the code
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      raw_q <= CODE_RST;
      chan_q <= CH_RST;
      applied_q <= 1'b0;
      d1_q <= '0;
      d2_q <= '0;
    end else if (accepted) begin
      raw_q <= raw_code_in;
      chan_q <= channel_in;
      applied_q <= grp_any;
      d1_q <= d1_d;
      d2_q <= d2_d;
    end
  end

  // Remember a negative numerator through the division
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      neg_q <= 1'b0;
    end else if (div_start) begin
      neg_q <= num_neg;
    end
  end

  // Result registers; the code holds until the next result
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      code_q <= CODE_RST;
      valid_q <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      valid_q <= (state_q == ST_DIV) && div_done;
      if ((state_q == ST_DIV) && div_done) begin
        code_q <= sat_code;
        clamp_q <= over || neg_q;
      end
    end
  end

  // Outputs
  assign corrected_code_out = code_q;
  assign result_valid_out = valid_q;
  assign result_channel_out = chan_q;
  assign cal_applied_out = applied_q;
  assign clamped_out = clamp_q;

  // Checks of the datapath against its cause
  sequence s_take;
    raw_valid_in && raw_ready_out;
  endsequence

  sequence s_take_ident;
    raw_valid_in && raw_ready_out && (d1_d == '0) && (d2_d == '0);
  endsequence

  AST_RESULT_TIME: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    s_take |-> ##28 result_valid_out)
    else $error("result pulse not 28 cycles after accept");

  AST_VALID_PULSE: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    result_valid_out |=> !result_valid_out)
    else $error("result valid longer than one cycle");

  AST_BUSY_AFTER_TAKE: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    s_take |=> !raw_ready_out [*8])
    else $error("ready returned during correction");

  AST_IDENTITY: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    s_take_ident |-> ##28
      (corrected_code_out == $past(raw_code_in, 28)))
    else $error("zero deviation did not return raw code");

  AST_GROUP_A_D1: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    accepted && grp_a |=> (d1_q == $past(dev_term[0])))
    else $error("group A low deviation not channel-3 trim");

  AST_CH8_D2: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    accepted && is_ch8 |=>
      (d2_q == $past(dev_term[1] + dev_term[3])))
    else $error("channel 8 high deviation not combined");

  AST_SIGN_NEG: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    cal_fuse_reg_1_in[SIGN_BIT] |->
      (dev_term[0] == -$signed({2'b00, mag[0]})))
    else $error("sign bit one did not negate magnitude");

  AST_GAIN_POS: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_q == ST_LOAD) |-> (den > 0) && (den < 2 ** (DIVISOR_W - 1)))
    else $error("gain denominator outside the divisor range");

  AST_NEG_CLAMP: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_q == ST_LOAD) && num_neg |-> ##27
      (result_valid_out && corrected_code_out == CODE_RST && clamped_out))
    else $error("negative result not clamped to zero");

  AST_SAT_HIGH: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_q == ST_DIV) && div_done && over |=>
      (corrected_code_out == CODE_MAX))
    else $error("overrange result not saturated");

endmodule
`default_nettype wire

// ===== test/conv_source.sv
// Model of the converter control that hands raw codes to the block.
// Assumes the bench asks with go_in and reads ready as a level.
`timescale 1ns/1ps
`default_nettype none
module conv_source
  import adc_cal_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic go_in, // Bench asks for one request
  input wire logic hold_in, // Keep valid up after a take
  input wire logic [CH_W-1:0] ch_in,
  input wire logic [CODE_W-1:0] code_in,
  input wire logic raw_ready_in,
  output logic raw_valid_out,
  output logic [CH_W-1:0] channel_out,
  output logic [CODE_W-1:0] raw_code_out
);
  logic go_s, hold_s, ready_s, rst_s; // Settled copies
  logic [CH_W-1:0] ch_s;
  logic [CODE_W-1:0] code_s;
  initial begin
    raw_valid_out = 1'b0;
    channel_out = CH_RST;
    raw_code_out = CODE_RST;
  end
  // Sample at the falling edge so the rising edge never races the bench
  always @(negedge ref_clk_in) begin
    {go_s, hold_s, ready_s, rst_s} = {go_in, hold_in, raw_ready_in, reset_in};
    ch_s = ch_in;
    code_s = code_in;
  end
  // Act just after the rising edge; a taken request is released unless hold_in was set
  always @(posedge ref_clk_in) begin
    #1;
    if (rst_s) begin
      raw_valid_out = 1'b0;
    end else if (raw_valid_out && ready_s && !hold_s) begin
      // Released lines show garbage, not the last value
      raw_valid_out = 1'b0;
      channel_out = ~channel_out;
      raw_code_out = ~raw_code_out;
    end else if (!raw_valid_out && go_s) begin
      raw_valid_out = 1'b1;
      channel_out = ch_s;
      raw_code_out = code_s;
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the two-point correction datapath.
// Assumes conv_source issues requests and fuses are driven as levels.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import adc_cal_pkg::*;
;
  logic clk, rst, go, hold, valid, ready, res_valid, applied, clamped;
  logic [4:0] ch, raw_ch, out_ch;
  logic [11:0] code, raw_code, out_code;
  logic [7:0] fz [10]; // Fuses 1,2,3,4,7,8,10,12,14,16
  int mismatches, samples_checked;
  conv_source src (.ref_clk_in(clk), .reset_in(rst), .go_in(go),
    .hold_in(hold), .ch_in(ch), .code_in(code), .raw_ready_in(ready),
    .raw_valid_out(valid), .channel_out(raw_ch), .raw_code_out(raw_code));
  adc_two_point_calibration DUT (.ref_clk_in(clk), .reset_in(rst),
    .cal_fuse_reg_1_in(fz[0]), .cal_fuse_reg_2_in(fz[1]),
    .cal_fuse_reg_3_in(fz[2]), .cal_fuse_reg_4_in(fz[3]),
    .cal_fuse_reg_7_in(fz[4]), .cal_fuse_reg_8_in(fz[5]),
    .cal_fuse_reg_10_in(fz[6]), .cal_fuse_reg_12_in(fz[7]),
    .cal_fuse_reg_14_in(fz[8]), .cal_fuse_reg_16_in(fz[9]),
    .channel_in(raw_ch), .raw_code_in(raw_code), .raw_valid_in(valid),
    .raw_ready_out(ready), .corrected_code_out(out_code),
    .result_channel_out(out_ch), .result_valid_out(res_valid),
    .cal_applied_out(applied), .clamped_out(clamped));
  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic int sm(input int m, input logic s);
    return s ? -m : m; // Sign bit one is negative
  endfunction
  // Expected {applied, clamped, code}, worked out in plain integers
  function automatic logic [13:0] model(input logic [4:0] c,
                                        input logic [11:0] a);
    int d1, d2, n, den, q, ai;
    logic ap, cl;
    ai = a;
    d1 = sm(fz[2][4:0] * 4 + fz[0][2:1], fz[0][0]);
    d2 = sm(fz[3][5:0] * 4 + fz[1][2:1], fz[1][0]);
    if (c == 5'h08) begin
      d1 += sm(fz[5][4:3] * 16 + fz[4][4:1], fz[4][0]);
      d2 += sm(fz[6][4:0] * 4 + fz[5][2:1], fz[5][0]);
    end
    if (c == 5'h09) begin
      d1 += sm(fz[8][4:3] * 16 + fz[7][4:1], fz[7][0]);
      d2 += sm(fz[9][4:0] * 4 + fz[8][2:1], fz[8][0]);
    end
    ap = c inside {[0:6], 12, 13, 8, 9};
    if (!ap) return {2'b00, a};
    n = (ai - d1) * 1835 + (d2 - d1) * 1441;
    den = 1835 + d2 - d1;
    cl = 1'b0;
    if (n < 0) begin
      q = 0;
      cl = 1'b1;
    end else begin
      q = (2 * n + den) / (2 * den);
      if (q > 4095) begin
        q = 4095;
        cl = 1'b1;
      end
    end
    return {ap, cl, q[11:0]};
  endfunction
  // Count falling edges until the result pulse, bounded
  task wait_res(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (res_valid !== 1'b1 && n < 60);
  endtask
  task wait_take;
    int n;
    n = 0;
    while (!(valid === 1'b1 && ready === 1'b1) && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Judge one result at its pulse against the model
  task judge(input logic [4:0] c, input logic [11:0] a, input int n);
    logic [13:0] e;
    e = model(c, a);
    check(16'(n), 16'h001C);
    check(16'(out_code), 16'(e[11:0]));
    check(16'(clamped), 16'(e[12]));
    check(16'(applied), 16'(e[13]));
    check(16'(out_ch), 16'(c));
  endtask
  // One request, then a check that the pulse lasts one cycle
  task xfer(input logic [4:0] c, input logic [11:0] a);
    int n;
    ch = c;
    code = a;
    go = 1'b1;
    wait_take();
    @(posedge clk);
    #1 go = 1'b0;
    wait_res(n);
    judge(c, a, n);
    @(negedge clk);
    check(16'(res_valid), 16'h0000);
    @(posedge clk);
    #1;
  endtask
  task t_reset;
    @(negedge clk);
    check(16'({ready, res_valid, applied, clamped}), 16'h0008);
    check(16'(out_ch), 16'h0000);
    check(16'(out_code), 16'h0000);
    // Leave on the usual stimulus point, just after a rising edge
    @(posedge clk);
    #1;
  endtask
  task automatic t_group_a;
    logic [4:0] grp [9] = '{0, 1, 2, 3, 4, 5, 6, 12, 13};
    fz = '{8'hE5, 8'hF2, 8'hF3, 8'hEA, 0, 0, 0, 0, 0, 0};
    foreach (grp[i]) xfer(grp[i], 12'h100 + 12'(i) * 12'h1C3);
  endtask
  task t_sign;
    for (int s = 0; s < 4; s++) begin
      fz[0][0] = s[0];
      fz[1][0] = s[1];
      xfer(5'h03, 12'h7FF);
    end
  endtask
  task t_extra;
    fz = '{8'hE5, 8'hF3, 8'hF3, 8'hEA, 8'h13, 8'hFB, 8'hF5, 8'h0C,
      8'hF6, 8'h09};
    xfer(5'h08, 12'h5A1);
    xfer(5'h09, 12'hB22);
    fz = '{8'hE5, 8'hF3, 8'hF3, 8'hEA, 8'h1E, 8'h1A, 8'h03, 8'h1F,
      8'h1B, 8'h1E};
    xfer(5'h08, 12'hCCD);
    xfer(5'h09, 12'h333);
  endtask
  task automatic t_pass;
    logic [4:0] oth [6] = '{7, 10, 11, 14, 15, 31};
    foreach (oth[i]) xfer(oth[i], i[0] ? 12'hFFF : 12'h000);
  endtask
  task t_clamp;
    fz = '{8'h06, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    xfer(5'h03, 12'h000);
    fz = '{8'h07, 8'h07, 8'h1F, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    xfer(5'h03, 12'hFFF);
  endtask
  // Valid held through the busy span: refused until the pulse cycle
  task t_b2b;
    int n;
    ch = 5'h0D;
    code = 12'h9AB;
    hold = 1'b1;
    go = 1'b1;
    wait_take();
    @(posedge clk);
    // Drop hold now so the source lets go right after the second take
    #1 {hold, go} = 2'b00;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(valid === 1'b1 && ready === 1'b1) && n < 60);
    check(16'(n), 16'h001C);
    judge(5'h0D, 12'h9AB, n);
    @(posedge clk);
    wait_res(n);
    judge(5'h0D, 12'h9AB, n);
  endtask
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
  initial begin
    {rst, go, hold, ch, code} = {3'b100, 5'h00, 12'h000};
    fz = '{default: 8'h00};
    mismatches = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_group_a();
    t_sign();
    t_extra();
    t_pass();
    t_clamp();
    t_b2b();
    end_sim();
  end
endmodule
`default_nettype wire
